/* File: tsr_host_model.sv */
// Host side of the register port, single byte accesses
`timescale 1ns/10ps
module tsr_host_model
(
    input wire logic clk_in,
    output logic [7:0] cmd_out,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] wdata_out,
    input wire logic [7:0] rdata_in,
    input wire logic valid_in
);
    initial
    begin
        cmd_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end

    task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data);
        @(posedge clk_in);
        cmd_out <= cmd;
        wdata_out <= data;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        cmd_out <= ~cmd;
        wdata_out <= ~data;
    endtask

    task automatic read_reg(input logic [7:0] cmd, output logic [7:0] data, output logic ok);
        @(posedge clk_in);
        cmd_out <= cmd;
        rd_out <= 1'b1;
        repeat (2) @(posedge clk_in);
        ok = valid_in;
        data = rdata_in;
        rd_out <= 1'b0;
        cmd_out <= ~cmd;
    endtask
endmodule

/* File: tsr_limit_cmp.sv */
// Signed comparison of one channel code against its two limits
`timescale 1ns/10ps
module tsr_limit_cmp
(
    input wire logic check_in,
    input wire logic [7:0] temp_in,
    input wire logic [7:0] upper_in,
    input wire logic [7:0] lower_in,
    output logic above_out,
    output logic below_out
);
    always_comb
    begin
        above_out = check_in && ($signed(temp_in) > $signed(upper_in)); // RQ15
        below_out = check_in && ($signed(temp_in) < $signed(lower_in)); // RQ15
    end
endmodule

/* File: tsr_pkg.sv */
// Shared constants and types of the thermal sensor register set
package tsr_pkg;
    // Host command codes
    localparam logic [7:0] CMD_RD_LOCAL_TEMP = 8'h00;
    localparam logic [7:0] CMD_RD_REMOTE_TEMP = 8'h01;
    localparam logic [7:0] CMD_RD_EVENT_FLAGS = 8'h02;
    localparam logic [7:0] CMD_RD_CONTROL = 8'h03;
    localparam logic [7:0] CMD_RD_RATE = 8'h04;
    localparam logic [7:0] CMD_RD_LOCAL_UPPER = 8'h05;
    localparam logic [7:0] CMD_RD_LOCAL_LOWER = 8'h06;
    localparam logic [7:0] CMD_RD_REMOTE_UPPER = 8'h07;
    localparam logic [7:0] CMD_RD_REMOTE_LOWER = 8'h08;
    localparam logic [7:0] CMD_WR_CONTROL = 8'h09;
    localparam logic [7:0] CMD_WR_RATE = 8'h0A;
    localparam logic [7:0] CMD_WR_LOCAL_UPPER = 8'h0B;
    localparam logic [7:0] CMD_WR_LOCAL_LOWER = 8'h0C;
    localparam logic [7:0] CMD_WR_REMOTE_UPPER = 8'h0D;
    localparam logic [7:0] CMD_WR_REMOTE_LOWER = 8'h0E;
    localparam logic [7:0] CMD_ONE_SHOT = 8'h0F;
    localparam logic [7:0] CMD_RD_MAKER_ID = 8'hFE;
    localparam logic [7:0] CMD_RD_REVISION = 8'hFF;
    // Answer to an unmapped command
    localparam logic [7:0] ERROR_CODE = 8'hFF;
    // Event flag bit positions
    localparam int BIT_BUSY = 7;
    localparam int BIT_LOCAL_UPPER = 6;
    localparam int BIT_LOCAL_LOWER = 5;
    localparam int BIT_REMOTE_UPPER = 4;
    localparam int BIT_REMOTE_LOWER = 3;
    localparam int BIT_DIODE_FAULT = 2;
    // Control bit positions
    localparam int BIT_ALERT_MASK = 7;
    localparam int BIT_STANDBY = 6;
    // Values after reset
    localparam logic [7:0] RESET_TEMP = 8'h00;
    localparam logic [7:0] RESET_LOCAL_UPPER = 8'h7F;
    localparam logic [7:0] RESET_LOWER = 8'hC9;
    localparam logic [7:0] RESET_REMOTE_UPPER = 8'h7F;
    localparam logic [2:0] RESET_RATE = 3'h2;
    // Code limits and the open diode code
    localparam int CODE_MAX = 127;
    localparam int CODE_MIN = -128;
    localparam logic [7:0] CODE_TOP = 8'h7F;
    localparam logic [7:0] CODE_BOTTOM = 8'h80;
    // Fixed-point half degree in raw quarter-degree units
    localparam int RAW_HALF = 2;
    localparam int RAW_FRAC_BITS = 2;
    // Critical limit decode: base plus step per select index
    localparam logic [7:0] TRIP_BASE = 8'h55;
    localparam logic [7:0] TRIP_STEP = 8'h05;
    // Identification, value arbitrary
    localparam logic [7:0] MAKER_ID = 8'h5A;
    localparam logic [7:0] SILICON_REV = 8'h01;
    // Read answer state machine
    typedef enum logic [1:0]
    {
        RD_IDLE = 2'b01,
        RD_ANSWER = 2'b10
    } tsr_rd_state_t;
endpackage

/* File: tsr_round.sv */
// Rounds and clamps a quarter-degree sample to an 8-bit code
`timescale 1ns/10ps
module tsr_round #(parameter int RAW_W = 11)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    tsr_sample_if.rnd smp
);
    typedef struct packed
    {
        logic valid;
        logic chan;
        logic [7:0] code;
    } tsr_round_state_t;

    tsr_round_state_t state_reg;
    tsr_round_state_t state_next;
    logic signed [RAW_W:0] sum;
    logic signed [RAW_W:0] whole;

    always_comb
    begin
        state_next = state_reg;
        sum = {smp.raw[RAW_W-1], smp.raw} + (RAW_W + 1)'(tsr_pkg::RAW_HALF);
        whole = sum >>> tsr_pkg::RAW_FRAC_BITS;
        state_next.valid = smp.valid;
        state_next.chan = smp.chan;
        if (smp.chan && smp.diode_open)
        begin
            state_next.code = tsr_pkg::CODE_TOP; // RQ8
        end
        else if (whole > tsr_pkg::CODE_MAX)
        begin
            state_next.code = tsr_pkg::CODE_TOP; // RQ1
        end
        else if (whole < tsr_pkg::CODE_MIN)
        begin
            state_next.code = tsr_pkg::CODE_BOTTOM;
        end
        else
        begin
            state_next.code = whole[7:0]; // RQ2 RQ3
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign smp.code_valid = state_reg.valid;
    assign smp.code_chan = state_reg.chan;
    assign smp.code = state_reg.code;
endmodule

/* File: tsr_sample_if.sv */
// Conversion sample carrier between the register set and its rounding stage
`timescale 1ns/10ps
interface tsr_sample_if #(parameter int RAW_W = 11);
    logic valid;
    logic chan;
    logic diode_open;
    logic signed [RAW_W-1:0] raw;
    logic code_valid;
    logic code_chan;
    logic [7:0] code;
    modport src (output valid, output chan, output diode_open, output raw,
        input code_valid, input code_chan, input code);
    modport rnd (input valid, input chan, input diode_open, input raw,
        output code_valid, output code_chan, output code);
endinterface

/* File: tsr_top.sv */
// Register set of a two-channel temperature sensor
// What this block does
// RQ1 - Readings above +127 degrees saturate to code 01111111.
// RQ2 - Positive fractions round to nearest degree, exact half rounds up.
// RQ3 - Negative half rounds toward zero, below it away from zero.
// RQ4 - Event flag bit 7 shows converter busy, 0 when idle.
// RQ5 - Sticky bits 6..3: local upper, local lower, remote upper, remote lower.
// RQ6 - Bit 2 flags a faulty remote diode; bits 1 and 0 read zero.
// RQ7 - Reading the event flags clears every flag except busy bit 7.
// RQ8 - An open remote diode loads the remote temperature with +127.
// RQ9 - Temperatures reset to zero and update right away without a command.
// RQ10 - Standby pin low at power-up stops conversions, temperatures stay zero.
// RQ11 - Read-only revision code starting at 01h.
// RQ12 - Critical limit set only from the select pins, never by the host.
// RQ13 - Every register is exactly 8 bits wide.
// RQ14 - Reset loads both lower limits with C9h and remote upper with 7Fh.
// RQ15 - Upper flag when temperature exceeds, lower flag when below, signed.
`timescale 1ns/10ps
module tsr_top #(
    parameter int RAW_W = 11,
    parameter logic [7:0] MAKER_ID = tsr_pkg::MAKER_ID,
    parameter logic [7:0] SILICON_REV = tsr_pkg::SILICON_REV
)
(
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [7:0] REG_CMD_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [7:0] REG_WDATA_IN,
    output logic [7:0] REG_RDATA_OUT,
    output logic REG_RDATA_VALID_OUT,
    input wire logic CONV_BUSY_IN,
    input wire logic CONV_DONE_IN,
    input wire logic CONV_CHANNEL_IN,
    input wire logic [RAW_W-1:0] CONV_RAW_IN,
    input wire logic DIODE_OPEN_IN,
    input wire logic STANDBY_INPUT_PIN_N_IN,
    input wire logic [3:0] CRITICAL_SELECT_PINS_IN,
    output logic CONV_ENABLE_OUT,
    output logic [2:0] SAMPLE_RATE_SELECT_OUT,
    output logic ALERT_MASK_OUT,
    output logic ONE_SHOT_OUT,
    output logic [7:0] CRITICAL_LIMIT_OUT
);
    // Limit index: 0 local upper, 1 local lower, 2 remote upper, 3 remote lower
    typedef struct packed
    {
        logic [7:0] local_temperature;
        logic [7:0] remote_temperature;
        logic [3:0] limit_events;
        logic remote_diode_fault;
        logic alert_mask;
        logic standby;
        logic [2:0] sample_rate_select;
        logic [3:0][7:0] limits;
        logic [7:0] pin_set_critical_limit;
        logic pin_caught;
        logic pin_run;
        logic conv_enable;
        logic one_shot;
        logic [7:0] rdata;
        tsr_pkg::tsr_rd_state_t rd_state;
    } tsr_top_state_t;

    tsr_top_state_t state_reg;
    tsr_top_state_t state_next;
    logic [1:0] above;
    logic [1:0] below;
    logic [7:0] event_flags;
    logic [1:0] sel_hi;
    logic [1:0] sel_lo;
    logic [7:0] sel_index;

    tsr_sample_if #(.RAW_W(RAW_W)) sample();

    // Samples pass to rounding only while conversions run
    assign sample.valid = CONV_DONE_IN && state_reg.conv_enable; // RQ10
    assign sample.chan = CONV_CHANNEL_IN;
    assign sample.diode_open = DIODE_OPEN_IN;
    assign sample.raw = CONV_RAW_IN;

    tsr_round #(.RAW_W(RAW_W)) u_round
    (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RST_N_IN),
        .smp(sample.rnd)
    );

    // One comparator per channel
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_cmp
        tsr_limit_cmp u_cmp
        (
            .check_in(sample.code_valid && (sample.code_chan == 1'(ch))),
            .temp_in(sample.code),
            .upper_in(state_reg.limits[2 * ch]),
            .lower_in(state_reg.limits[2 * ch + 1]),
            .above_out(above[ch]),
            .below_out(below[ch])
        );
    end

    // Flags as the host sees them
    always_comb
    begin
        event_flags = 8'h00;
        event_flags[tsr_pkg::BIT_BUSY] = CONV_BUSY_IN && state_reg.conv_enable; // RQ4
        event_flags[tsr_pkg::BIT_LOCAL_UPPER] = state_reg.limit_events[0]; // RQ5
        event_flags[tsr_pkg::BIT_LOCAL_LOWER] = state_reg.limit_events[1];
        event_flags[tsr_pkg::BIT_REMOTE_UPPER] = state_reg.limit_events[2];
        event_flags[tsr_pkg::BIT_REMOTE_LOWER] = state_reg.limit_events[3];
        event_flags[tsr_pkg::BIT_DIODE_FAULT] = state_reg.remote_diode_fault; // RQ6
    end

    // Three-level select pins: 0 low, 1 open, 2 high
    always_comb
    begin
        sel_hi = CRITICAL_SELECT_PINS_IN[3:2];
        sel_lo = CRITICAL_SELECT_PINS_IN[1:0];
        if (sel_hi > 2'h2)
        begin
            sel_hi = 2'h2;
        end
        if (sel_lo > 2'h2)
        begin
            sel_lo = 2'h2;
        end
        sel_index = 8'(sel_hi) * 8'h03 + 8'(sel_lo);
    end

    always_comb
    begin
        state_next = state_reg;
        state_next.one_shot = 1'b0;

        // Critical limit follows the pins only
        state_next.pin_set_critical_limit = 8'(tsr_pkg::TRIP_BASE + sel_index * tsr_pkg::TRIP_STEP); // RQ12

        // Standby pin caught once after reset release
        if (!state_reg.pin_caught)
        begin
            state_next.pin_caught = 1'b1;
            state_next.pin_run = STANDBY_INPUT_PIN_N_IN; // RQ10
        end
        state_next.conv_enable = state_next.pin_caught && state_next.pin_run && !state_reg.standby; // RQ9

        // New codes land in the temperature registers
        if (sample.code_valid)
        begin
            if (sample.code_chan)
            begin
                state_next.remote_temperature = sample.code; // RQ8
            end
            else
            begin
                state_next.local_temperature = sample.code; // RQ9
            end
        end

        // Host read; event flags clear as they are read
        case (state_reg.rd_state)
            tsr_pkg::RD_IDLE:
            begin
                if (REG_RD_IN)
                begin
                    state_next.rd_state = tsr_pkg::RD_ANSWER;
                    case (REG_CMD_IN)
                        tsr_pkg::CMD_RD_LOCAL_TEMP:
                        begin
                            state_next.rdata = state_reg.local_temperature;
                        end
                        tsr_pkg::CMD_RD_REMOTE_TEMP:
                        begin
                            state_next.rdata = state_reg.remote_temperature;
                        end
                        tsr_pkg::CMD_RD_EVENT_FLAGS:
                        begin
                            state_next.rdata = event_flags;
                            state_next.limit_events = 4'h0; // RQ7
                            state_next.remote_diode_fault = 1'b0; // RQ7
                        end
                        tsr_pkg::CMD_RD_CONTROL:
                        begin
                            state_next.rdata = 8'h00;
                            state_next.rdata[tsr_pkg::BIT_ALERT_MASK] = state_reg.alert_mask;
                            state_next.rdata[tsr_pkg::BIT_STANDBY] = state_reg.standby;
                        end
                        tsr_pkg::CMD_RD_RATE:
                        begin
                            state_next.rdata = {5'h00, state_reg.sample_rate_select};
                        end
                        tsr_pkg::CMD_RD_LOCAL_UPPER:
                        begin
                            state_next.rdata = state_reg.limits[0];
                        end
                        tsr_pkg::CMD_RD_LOCAL_LOWER:
                        begin
                            state_next.rdata = state_reg.limits[1];
                        end
                        tsr_pkg::CMD_RD_REMOTE_UPPER:
                        begin
                            state_next.rdata = state_reg.limits[2];
                        end
                        tsr_pkg::CMD_RD_REMOTE_LOWER:
                        begin
                            state_next.rdata = state_reg.limits[3];
                        end
                        tsr_pkg::CMD_RD_MAKER_ID:
                        begin
                            state_next.rdata = MAKER_ID;
                        end
                        tsr_pkg::CMD_RD_REVISION:
                        begin
                            state_next.rdata = SILICON_REV; // RQ11
                        end
                        default:
                        begin
                            state_next.rdata = tsr_pkg::ERROR_CODE;
                        end
                    endcase
                end
            end
            tsr_pkg::RD_ANSWER:
            begin
                state_next.rd_state = tsr_pkg::RD_IDLE;
            end
            default:
            begin
                state_next.rd_state = tsr_pkg::RD_IDLE;
            end
        endcase

        // Host write; read-only and unknown codes are ignored
        if (REG_WR_IN)
        begin
            case (REG_CMD_IN)
                tsr_pkg::CMD_WR_CONTROL:
                begin
                    state_next.alert_mask = REG_WDATA_IN[tsr_pkg::BIT_ALERT_MASK];
                    state_next.standby = REG_WDATA_IN[tsr_pkg::BIT_STANDBY];
                end
                tsr_pkg::CMD_WR_RATE:
                begin
                    state_next.sample_rate_select = REG_WDATA_IN[2:0];
                end
                tsr_pkg::CMD_WR_LOCAL_UPPER:
                begin
                    state_next.limits[0] = REG_WDATA_IN;
                end
                tsr_pkg::CMD_WR_LOCAL_LOWER:
                begin
                    state_next.limits[1] = REG_WDATA_IN;
                end
                tsr_pkg::CMD_WR_REMOTE_UPPER:
                begin
                    state_next.limits[2] = REG_WDATA_IN;
                end
                tsr_pkg::CMD_WR_REMOTE_LOWER:
                begin
                    state_next.limits[3] = REG_WDATA_IN;
                end
                tsr_pkg::CMD_ONE_SHOT:
                begin
                    state_next.one_shot = 1'b1;
                end
                default:
                begin
                    state_next.one_shot = 1'b0;
                end
            endcase
        end

        // New events win over a clear in the same cycle
        for (int ch = 0; ch < 2; ch++)
        begin
            if (above[ch])
            begin
                state_next.limit_events[2 * ch] = 1'b1; // RQ5
            end
            if (below[ch])
            begin
                state_next.limit_events[2 * ch + 1] = 1'b1; // RQ5
            end
        end
        if (sample.valid && CONV_CHANNEL_IN && DIODE_OPEN_IN)
        begin
            state_next.remote_diode_fault = 1'b1; // RQ6
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            state_reg.local_temperature <= tsr_pkg::RESET_TEMP; // RQ9
            state_reg.remote_temperature <= tsr_pkg::RESET_TEMP; // RQ9
            state_reg.limit_events <= 4'h0;
            state_reg.remote_diode_fault <= 1'b0;
            state_reg.alert_mask <= 1'b0;
            state_reg.standby <= 1'b0;
            state_reg.sample_rate_select <= tsr_pkg::RESET_RATE;
            state_reg.limits[0] <= tsr_pkg::RESET_LOCAL_UPPER;
            state_reg.limits[1] <= tsr_pkg::RESET_LOWER; // RQ14
            state_reg.limits[2] <= tsr_pkg::RESET_REMOTE_UPPER; // RQ14
            state_reg.limits[3] <= tsr_pkg::RESET_LOWER; // RQ14
            state_reg.pin_set_critical_limit <= tsr_pkg::TRIP_BASE;
            state_reg.pin_caught <= 1'b0;
            state_reg.pin_run <= 1'b0;
            state_reg.conv_enable <= 1'b0;
            state_reg.one_shot <= 1'b0;
            state_reg.rdata <= 8'h00;
            state_reg.rd_state <= tsr_pkg::RD_IDLE;
        end
        else
        begin
            state_reg <= state_next; // RQ13
        end
    end

    assign REG_RDATA_OUT = state_reg.rdata;
    assign REG_RDATA_VALID_OUT = (state_reg.rd_state == tsr_pkg::RD_ANSWER);
    assign CONV_ENABLE_OUT = state_reg.conv_enable;
    assign SAMPLE_RATE_SELECT_OUT = state_reg.sample_rate_select;
    assign ALERT_MASK_OUT = state_reg.alert_mask;
    assign ONE_SHOT_OUT = state_reg.one_shot;
    assign CRITICAL_LIMIT_OUT = state_reg.pin_set_critical_limit;
endmodule

/* File: tsr_top_asserts.sv */
// Port checks of the temperature sensor register set
`timescale 1ns/10ps
module tsr_top_asserts #(
    parameter int RAW_W = 11,
    parameter logic [7:0] SILICON_REV = 8'h01
)
(
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [7:0] REG_CMD_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    input wire logic REG_RDATA_VALID_OUT,
    input wire logic CONV_BUSY_IN,
    input wire logic CONV_DONE_IN,
    input wire logic CONV_CHANNEL_IN,
    input wire logic [RAW_W-1:0] CONV_RAW_IN,
    input wire logic DIODE_OPEN_IN,
    input wire logic STANDBY_INPUT_PIN_N_IN,
    input wire logic [3:0] CRITICAL_SELECT_PINS_IN,
    input wire logic CONV_ENABLE_OUT,
    input wire logic [7:0] CRITICAL_LIMIT_OUT
);
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    function automatic logic [7:0] round_code(input logic [RAW_W-1:0] raw);
        logic signed [RAW_W:0] q;
        q = ($signed({raw[RAW_W-1], raw}) + 2) >>> 2;
        if (q > 127)
            return 8'h7F;
        if (q < -128)
            return 8'h80;
        return q[7:0];
    endfunction

    sequence rd_of(logic [7:0] cmd);
        REG_RD_IN && !REG_RDATA_VALID_OUT && REG_CMD_IN == cmd;
    endsequence
    sequence sample_of(logic chan);
        CONV_DONE_IN && CONV_ENABLE_OUT && CONV_CHANNEL_IN == chan;
    endsequence
    sequence answer(logic [7:0] val);
        REG_RDATA_VALID_OUT && REG_RDATA_OUT == val;
    endsequence

    chk_hot_clamp: assert property (sample_of(1'b0) ##0 ($signed(CONV_RAW_IN) >= 506)
        ##2 rd_of(tsr_pkg::CMD_RD_LOCAL_TEMP) |=> answer(8'h7F))
        else $error("hot local reading not clamped");
    chk_local_round: assert property (sample_of(1'b0) ##2 rd_of(tsr_pkg::CMD_RD_LOCAL_TEMP)
        |=> answer(round_code($past(CONV_RAW_IN, 3))))
        else $error("local code wrongly rounded");
    chk_remote_round: assert property (sample_of(1'b1) ##0 !DIODE_OPEN_IN
        ##2 rd_of(tsr_pkg::CMD_RD_REMOTE_TEMP) |=> answer(round_code($past(CONV_RAW_IN, 3))))
        else $error("remote code wrongly rounded");
    chk_open_diode: assert property (sample_of(1'b1) ##0 DIODE_OPEN_IN
        ##2 rd_of(tsr_pkg::CMD_RD_REMOTE_TEMP) |=> answer(8'h7F))
        else $error("open diode not reported as top code");
    chk_rev_code: assert property (rd_of(tsr_pkg::CMD_RD_REVISION) |=> answer(SILICON_REV))
        else $error("revision code wrong");
    chk_unmapped_read: assert property (REG_RD_IN && !REG_RDATA_VALID_OUT && REG_CMD_IN inside {[8'h10:8'hFD]}
        |=> answer(8'hFF))
        else $error("unmapped read not answered with all ones");
    chk_flag_low_bits: assert property (rd_of(tsr_pkg::CMD_RD_EVENT_FLAGS)
        |=> REG_RDATA_VALID_OUT && REG_RDATA_OUT[1:0] == 2'b00)
        else $error("reserved flag bits not zero");
    chk_busy_shown: assert property (rd_of(tsr_pkg::CMD_RD_EVENT_FLAGS)
        ##0 (CONV_BUSY_IN && $past(CONV_BUSY_IN) && CONV_ENABLE_OUT) |=> REG_RDATA_OUT[7])
        else $error("busy converter not shown");
    chk_idle_shown: assert property (rd_of(tsr_pkg::CMD_RD_EVENT_FLAGS)
        ##0 (!CONV_BUSY_IN && !$past(CONV_BUSY_IN)) |=> !REG_RDATA_OUT[7])
        else $error("idle converter shown busy");
    chk_standby_hold: assert property (!$past(RST_N_IN) && !STANDBY_INPUT_PIN_N_IN
        |=> !CONV_ENABLE_OUT [*8])
        else $error("conversions enabled in standby");
    chk_crit_no_host: assert property ($past(RST_N_IN) && REG_WR_IN && $stable(CRITICAL_SELECT_PINS_IN)
        |=> $stable(CRITICAL_LIMIT_OUT))
        else $error("host write changed critical limit");
endmodule

bind tsr_top tsr_top_asserts #(.RAW_W(RAW_W), .SILICON_REV(SILICON_REV)) u_chk (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .REG_CMD_IN(REG_CMD_IN), .REG_WR_IN(REG_WR_IN),
    .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RDATA_VALID_OUT(REG_RDATA_VALID_OUT),
    .CONV_BUSY_IN(CONV_BUSY_IN), .CONV_DONE_IN(CONV_DONE_IN), .CONV_CHANNEL_IN(CONV_CHANNEL_IN),
    .CONV_RAW_IN(CONV_RAW_IN), .DIODE_OPEN_IN(DIODE_OPEN_IN), .STANDBY_INPUT_PIN_N_IN(STANDBY_INPUT_PIN_N_IN),
    .CRITICAL_SELECT_PINS_IN(CRITICAL_SELECT_PINS_IN), .CONV_ENABLE_OUT(CONV_ENABLE_OUT),
    .CRITICAL_LIMIT_OUT(CRITICAL_LIMIT_OUT));

/* File: tsr_top_test.sv */
// Self-checking bench of the temperature sensor register set
`timescale 1ns/10ps
module tsr_top_test;
    localparam int RAW_W = 11;
    localparam logic [7:0] MAKER_ID = 8'h3C; // Arbitrary value
    localparam logic [7:0] RST_CMD [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
        8'h08, 8'hFE, 8'hFF, 8'h10};
    localparam logic [7:0] RST_EXP [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h7F, 8'hC9, 8'h7F,
        8'hC9, MAKER_ID, 8'h01, 8'hFF};
    localparam int RND_RAW [14] = '{520, 508, 506, 101, 2, 1, 0, -1, -2, -3, -4, -101, -219, -260};
    localparam logic [7:0] RND_EXP [14] = '{8'h7F, 8'h7F, 8'h7F, 8'h19, 8'h01, 8'h00, 8'h00, 8'h00,
        8'h00, 8'hFF, 8'hFF, 8'hE7, 8'hC9, 8'hBF};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic busy = 1'b0;
    logic done = 1'b0;
    logic chan = 1'b0;
    logic [RAW_W-1:0] raw = '0;
    logic diode_open = 1'b0;
    logic sleep_n = 1'b1;
    logic [3:0] sel_pins = 4'b0110;
    logic [7:0] cmd;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic valid;
    logic conv_en;
    logic [7:0] trip;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 sys_clk = ~sys_clk;

    tsr_top #(.RAW_W(RAW_W), .MAKER_ID(MAKER_ID), .SILICON_REV(8'h01)) DUT (
        .SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .REG_CMD_IN(cmd), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_RDATA_VALID_OUT(valid), .CONV_BUSY_IN(busy),
        .CONV_DONE_IN(done), .CONV_CHANNEL_IN(chan), .CONV_RAW_IN(raw), .DIODE_OPEN_IN(diode_open),
        .STANDBY_INPUT_PIN_N_IN(sleep_n), .CRITICAL_SELECT_PINS_IN(sel_pins), .CONV_ENABLE_OUT(conv_en),
        .SAMPLE_RATE_SELECT_OUT(), .ALERT_MASK_OUT(), .ONE_SHOT_OUT(), .CRITICAL_LIMIT_OUT(trip));

    tsr_host_model u_host (.clk_in(sys_clk), .cmd_out(cmd), .wr_out(wr), .rd_out(rd), .wdata_out(wdata),
        .rdata_in(rdata), .valid_in(valid));

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] c, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        u_host.read_reg(c, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d, exp);
    endtask

    task automatic sample(input logic ch, input logic [RAW_W-1:0] val, input logic op);
        @(posedge sys_clk);
        done <= 1'b1;
        chan <= ch;
        raw <= val;
        diode_open <= op;
        @(posedge sys_clk);
        done <= 1'b0;
        chan <= ~ch;
        raw <= ~val;
        diode_open <= ~op;
    endtask

    task automatic do_reset(input logic pin);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        sleep_n <= pin;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask

    task automatic t_reset_values;
        for (int i = 0; i < 12; i++)
            rd_check(RST_CMD[i], RST_EXP[i]);
        check(trip, 8'h6E);
        u_host.write_reg(8'h10, 8'h00);
        check(trip, 8'h6E);
    endtask

    task automatic t_round;
        for (int i = 0; i < 14; i++)
        begin
            sample(i[0], RAW_W'(RND_RAW[i]), 1'b0);
            rd_check({7'h00, i[0]}, RND_EXP[i]);
        end
    endtask

    task automatic t_flags;
        logic [7:0] d;
        logic ok;
        u_host.read_reg(8'h02, d, ok);
        u_host.write_reg(8'h0B, 8'h19);
        u_host.write_reg(8'h0C, 8'h19);
        u_host.write_reg(8'h0D, 8'h05);
        u_host.write_reg(8'h0E, 8'h00);
        sample(1'b0, RAW_W'(100), 1'b0);
        sample(1'b1, RAW_W'(4), 1'b0);
        rd_check(8'h02, 8'h00);
        sample(1'b0, RAW_W'(104), 1'b0);
        rd_check(8'h02, 8'h40);
        rd_check(8'h02, 8'h00);
        sample(1'b0, RAW_W'(96), 1'b0);
        sample(1'b1, RAW_W'(24), 1'b0);
        sample(1'b1, RAW_W'(-8), 1'b0);
        rd_check(8'h02, 8'h38);
        rd_check(8'h02, 8'h00);
    endtask

    task automatic t_diode;
        u_host.write_reg(8'h0D, 8'h7F);
        sample(1'b1, RAW_W'(40), 1'b1);
        rd_check(8'h01, 8'h7F);
        rd_check(8'h02, 8'h04);
        sample(1'b1, RAW_W'(40), 1'b0);
        rd_check(8'h01, 8'h0A);
        rd_check(8'h02, 8'h00);
    endtask

    task automatic t_busy;
        @(posedge sys_clk);
        busy <= 1'b1;
        rd_check(8'h02, 8'h80);
        @(posedge sys_clk);
        busy <= 1'b0;
        rd_check(8'h02, 8'h00);
        u_host.write_reg(8'h09, 8'hC0);
        rd_check(8'h03, 8'hC0);
        check({7'h00, conv_en}, 8'h00);
    endtask

    task automatic t_standby;
        do_reset(1'b0);
        sample(1'b0, RAW_W'(100), 1'b0);
        sample(1'b1, RAW_W'(100), 1'b0);
        rd_check(8'h00, 8'h00);
        rd_check(8'h01, 8'h00);
        check({7'h00, conv_en}, 8'h00);
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            stop_test();
        end
    end

    initial
    begin
        do_reset(1'b1);
        t_reset_values();
        t_round();
        t_flags();
        t_diode();
        t_busy();
        t_standby();
        stop_test();
    end
endmodule
